// file: rtl/rscd_top.sv
// Summary of operation
// - divider code zero stops the aux clock
// - codes 1-5 divide by six, else code+1
// - aux one edge: 0 fast, 2 slow
// - aux zero edge: 0 fast, 2 slow
// - second buffer: single, diff, crystal, off
// - second buffer kind bits 7:6, reset crystal
// - first buffer: single, diff, else off
// - first kind bits 5:4 reset diff; 3:2 reserved
// - source: auto, pin, forced first, forced second
// - source bits 1:0, reset to pin control
// - select pin obeyed only for source 01
// - pin low first, mid second, high auto
//
// Implementation choice: the APB interface to the registers.
`default_nettype none

module rscd_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // stored defaults
  input wire logic [7:0] eeprom_div,
  input wire logic [7:0] eeprom_edge,
  input wire logic [7:0] eeprom_insel,
  input wire logic eeprom_reload,
  // reference inputs and select pin
  input wire logic prim_ref_in,
  input wire logic sec_ref_in,
  input wire logic [1:0] ref_choice_pin,
  // lvcmos pre-divider output
  input wire logic prediv_tick,
  // configuration outputs
  output var logic aux_divider_zero_clk,
  output var logic aux_out_one_slow,
  output var logic aux_out_zero_slow,
  output var logic [1:0] first_ref_buffer_kind,
  output var logic [1:0] second_ref_buffer_kind,
  output var logic first_ref_buffer_on,
  output var logic second_ref_buffer_on,
  output var logic synth_ref_use_sec
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic pready_r;
  logic pready_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [3:0] edge_r;
  logic [3:0] edge_nxt;
  logic [7:0] insel_r;
  logic [7:0] insel_nxt;
  logic load_pend_r;
  logic load_pend_nxt;
  logic one_slow_r;
  logic one_slow_nxt;
  logic zero_slow_r;
  logic zero_slow_nxt;
  logic prim_on_r;
  logic prim_on_nxt;
  logic sec_on_r;
  logic sec_on_nxt;
  rscd_pkg::rscd_sel_t sel_r;
  rscd_pkg::rscd_sel_t sel_nxt;
  logic use_sec_r;
  logic use_sec_nxt;
  logic access;
  logic wr_done;
  logic hit;
  logic [7:0] rdata;
  logic [1:0] src;
  logic [1:0] prim_kind;
  logic [1:0] sec_kind;
  logic auto_mode;
  logic force_sec;
  logic prim_ok;
  logic sec_ok;
  logic aux_clk;

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  assign src = insel_r[rscd_pkg::SRC_LSB +: 2];
  assign prim_kind = insel_r[rscd_pkg::PRIM_KIND_LSB +: 2];
  assign sec_kind = insel_r[rscd_pkg::SEC_KIND_LSB +: 2];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  assign access = psel & penable;
  assign wr_done = access & pready_r & pwrite & pstrb[0] & hit;

  always_comb
  begin
    hit = 1'b1;
    rdata = 8'h00;
    unique case (paddr)
      rscd_pkg::ADDR_AUX_DIV:
        rdata = div_r;
      rscd_pkg::ADDR_EDGE_RATE:
        rdata = {4'h0, edge_r};
      rscd_pkg::ADDR_INSEL:
        rdata = insel_r;
      rscd_pkg::ADDR_STATUS:
      begin
        rdata[rscd_pkg::ST_USE_SEC] = use_sec_r;
        rdata[rscd_pkg::ST_PRIM_OK] = prim_ok;
        rdata[rscd_pkg::ST_SEC_OK] = sec_ok;
        rdata[rscd_pkg::ST_DIV_RUN] = div_r != rscd_pkg::DIV_OFF;
      end
      default:
        hit = 1'b0;
    endcase
    pready_nxt = access & ~pready_r;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (access & ~pready_r)
    begin
      pslverr_nxt = ~hit;
      if (!pwrite)
        prdata_nxt = {24'h00_0000, rdata};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb
  begin
    div_nxt = div_r;
    edge_nxt = edge_r;
    insel_nxt = insel_r;
    load_pend_nxt = 1'b0;
    if (load_pend_r | eeprom_reload)
    begin
      div_nxt = eeprom_div;
      edge_nxt = eeprom_edge[3:0];
      insel_nxt = eeprom_insel;
    end
    else if (wr_done)
    begin
      unique case (paddr)
        rscd_pkg::ADDR_AUX_DIV:
          div_nxt = pwdata[7:0];
        // edge fields kept, upper bits reserved
        rscd_pkg::ADDR_EDGE_RATE:
          edge_nxt = pwdata[3:0];
        rscd_pkg::ADDR_INSEL:
          insel_nxt = pwdata[7:0];
        default:
          div_nxt = div_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r <= rscd_pkg::AUX_DIV_RST;
      edge_r <= rscd_pkg::EDGE_RATE_RST;
      insel_r <= rscd_pkg::INSEL_RST;
      // defaults are sampled by a clock edge after release, never by the reset itself
      load_pend_r <= 1'b1;
    end
    else
    begin
      div_r <= div_nxt;
      edge_r <= edge_nxt;
      insel_r <= insel_nxt;
      load_pend_r <= load_pend_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pad and buffer controls
  // ----------------------------------------------------------------
  always_comb
  begin
    one_slow_nxt = edge_r[rscd_pkg::EDGE_ONE_LSB +: 2] == rscd_pkg::EDGE_SLOW;
    zero_slow_nxt = edge_r[rscd_pkg::EDGE_ZERO_LSB +: 2] == rscd_pkg::EDGE_SLOW;
    // first buffer: codes two and three both off; second buffer off for code three only
    prim_on_nxt = (prim_kind == rscd_pkg::KIND_SINGLE) || (prim_kind == rscd_pkg::KIND_DIFF);
    sec_on_nxt = sec_kind != rscd_pkg::KIND_OFF;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      one_slow_r <= 1'b0;
      zero_slow_r <= 1'b0;
      prim_on_r <= 1'b0;
      sec_on_r <= 1'b0;
    end
    else
    begin
      one_slow_r <= one_slow_nxt;
      zero_slow_r <= zero_slow_nxt;
      prim_on_r <= prim_on_nxt;
      sec_on_r <= sec_on_nxt;
    end
  end

  // ----------------------------------------------------------------
  // reference activity
  // ----------------------------------------------------------------
  rscd_ref_monitor u_prim_mon (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ref_in(prim_ref_in),
    .enable(prim_on_r),
    .valid(prim_ok)
  );

  rscd_ref_monitor u_sec_mon (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ref_in(sec_ref_in),
    .enable(sec_on_r),
    .valid(sec_ok)
  );

  // ----------------------------------------------------------------
  // synthesizer reference choice
  // ----------------------------------------------------------------
  always_comb
  begin
    auto_mode = 1'b0;
    force_sec = 1'b0;
    unique case (src)
      rscd_pkg::SRC_AUTO:
        auto_mode = 1'b1;
      rscd_pkg::SRC_PIN:
      begin
        unique case (ref_choice_pin)
          rscd_pkg::PIN_LOW:
            force_sec = 1'b0;
          rscd_pkg::PIN_MID:
            force_sec = 1'b1;
          rscd_pkg::PIN_HIGH:
            auto_mode = 1'b1;
          default:
            auto_mode = 1'b1;
        endcase
      end
      rscd_pkg::SRC_PRIM:
        force_sec = 1'b0;
      rscd_pkg::SRC_SEC:
        force_sec = 1'b1;
    endcase
    sel_nxt = sel_r;
    if (auto_mode)
    begin
      unique case (sel_r)
        rscd_pkg::RSCD_SEL_PRIM:
          if (!prim_ok && sec_ok)
            sel_nxt = rscd_pkg::RSCD_SEL_SEC;
        rscd_pkg::RSCD_SEL_SEC:
          if (prim_ok)
            sel_nxt = rscd_pkg::RSCD_SEL_PRIM;
      endcase
    end
    else if (force_sec)
      sel_nxt = rscd_pkg::RSCD_SEL_SEC;
    else
      sel_nxt = rscd_pkg::RSCD_SEL_PRIM;
    use_sec_nxt = sel_nxt == rscd_pkg::RSCD_SEL_SEC;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_r <= rscd_pkg::RSCD_SEL_PRIM;
      use_sec_r <= 1'b0;
    end
    else
    begin
      sel_r <= sel_nxt;
      use_sec_r <= use_sec_nxt;
    end
  end

  // ----------------------------------------------------------------
  // aux divider
  // ----------------------------------------------------------------
  rscd_aux_div u_aux_div (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ratio_code(div_r),
    .tick(prediv_tick),
    .div_clk(aux_clk)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign aux_divider_zero_clk = aux_clk;
  assign aux_out_one_slow = one_slow_r;
  assign aux_out_zero_slow = zero_slow_r;
  assign second_ref_buffer_kind = insel_r[rscd_pkg::SEC_KIND_LSB +: 2];
  assign first_ref_buffer_kind = insel_r[rscd_pkg::PRIM_KIND_LSB +: 2];
  assign first_ref_buffer_on = prim_on_r;
  assign second_ref_buffer_on = sec_on_r;
  assign synth_ref_use_sec = use_sec_r;

endmodule // rscd_top

`default_nettype wire

// file: inc/rscd_pkg.sv
`default_nettype none

package rscd_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_AUX_DIV = 8'h2e;
  localparam logic [7:0] IDX_EDGE_RATE = 8'h31;
  localparam logic [7:0] IDX_INSEL = 8'h32;
  localparam logic [7:0] IDX_STATUS = 8'h33;
  localparam logic [7:0] ADDR_AUX_DIV = {IDX_AUX_DIV[5:0], 2'b00};
  localparam logic [7:0] ADDR_EDGE_RATE = {IDX_EDGE_RATE[5:0], 2'b00};
  localparam logic [7:0] ADDR_INSEL = {IDX_INSEL[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_DIV_RST = 8'h00;
  localparam logic [3:0] EDGE_RATE_RST = 4'h0;
  localparam logic [7:0] INSEL_RST = 8'h95;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EDGE_ONE_LSB = 2;
  localparam int EDGE_ZERO_LSB = 0;
  localparam int SEC_KIND_LSB = 6;
  localparam int PRIM_KIND_LSB = 4;
  localparam int SRC_LSB = 0;
  localparam int ST_USE_SEC = 0;
  localparam int ST_PRIM_OK = 1;
  localparam int ST_SEC_OK = 2;
  localparam int ST_DIV_RUN = 3;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_FAST = 2'h0;
  localparam logic [1:0] EDGE_SLOW = 2'h2;
  localparam logic [1:0] KIND_SINGLE = 2'h0;
  localparam logic [1:0] KIND_DIFF = 2'h1;
  localparam logic [1:0] KIND_XTAL = 2'h2;
  localparam logic [1:0] KIND_OFF = 2'h3;
  localparam logic [1:0] SRC_AUTO = 2'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  localparam logic [1:0] SRC_PRIM = 2'h2;
  localparam logic [1:0] SRC_SEC = 2'h3;
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_MID = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  localparam logic [7:0] DIV_OFF = 8'h00;
  localparam logic [7:0] DIV_MIN_CODE = 8'h06;
  localparam logic [8:0] DIV_MIN_RATIO = 9'h006;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int REF_LOSS_NS = 1000;
  localparam logic [11:0] REF_LOSS_CYC = 12'(REF_LOSS_NS / CLK_PERIOD_NS);

  typedef enum logic [0:0] {
    RSCD_SEL_PRIM = 1'b0,
    RSCD_SEL_SEC = 1'b1
  } rscd_sel_t;

endpackage

`default_nettype wire

// file: rtl/rscd_aux_div.sv
`default_nettype none

module rscd_aux_div (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic [7:0] ratio_code,
  input wire logic tick,
  // divided clock
  output var logic div_clk
);

  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic [8:0] ratio_r;
  logic [8:0] ratio_nxt;
  logic out_r;
  logic out_nxt;
  logic [8:0] want;

  always_comb
  begin
    if (ratio_code < rscd_pkg::DIV_MIN_CODE)
      want = rscd_pkg::DIV_MIN_RATIO;
    else
      want = {1'b0, ratio_code} + 9'h001;
    cnt_nxt = cnt_r;
    ratio_nxt = ratio_r;
    out_nxt = out_r;
    if (ratio_code == rscd_pkg::DIV_OFF)
    begin
      cnt_nxt = 9'h000;
      ratio_nxt = want;
      out_nxt = 1'b0;
    end
    else if (tick)
    begin
      // new ratio only at period end, so no runt pulse on a change
      if (cnt_r >= ratio_r - 9'h001)
      begin
        cnt_nxt = 9'h000;
        ratio_nxt = want;
        out_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 9'h001;
        out_nxt = (cnt_r + 9'h001) < (ratio_r >> 1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= 9'h000;
      ratio_r <= rscd_pkg::DIV_MIN_RATIO;
      out_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      ratio_r <= ratio_nxt;
      out_r <= out_nxt;
    end
  end

  assign div_clk = out_r;

endmodule // rscd_aux_div

`default_nettype wire

// file: rtl/rscd_ref_monitor.sv
`default_nettype none

module rscd_ref_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // reference level and buffer enable
  input wire logic ref_in,
  input wire logic enable,
  // activity
  output var logic valid
);

  logic prev_r;
  logic prev_nxt;
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  logic valid_r;
  logic valid_nxt;

  always_comb
  begin
    prev_nxt = ref_in;
    cnt_nxt = cnt_r;
    valid_nxt = valid_r;
    if (!enable)
    begin
      cnt_nxt = 12'h000;
      valid_nxt = 1'b0;
    end
    else if (ref_in != prev_r)
    begin
      cnt_nxt = 12'h000;
      valid_nxt = 1'b1;
    end
    else if (cnt_r >= rscd_pkg::REF_LOSS_CYC - 12'h001)
    begin
      // quiet too long: the reference counts as lost
      valid_nxt = 1'b0;
    end
    else
    begin
      cnt_nxt = cnt_r + 12'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_r <= 1'b0;
      cnt_r <= 12'h000;
      valid_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign valid = valid_r;

endmodule // rscd_ref_monitor

`default_nettype wire

// file: bench/rscd_checker.sv
`default_nettype none

module rscd_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // defaults and pins
  input wire logic [7:0] eeprom_insel,
  input wire logic eeprom_reload,
  input wire logic [1:0] ref_choice_pin,
  input wire logic prediv_tick,
  // outputs
  input wire logic aux_divider_zero_clk,
  input wire logic aux_out_one_slow,
  input wire logic aux_out_zero_slow,
  input wire logic [1:0] first_ref_buffer_kind,
  input wire logic [1:0] second_ref_buffer_kind,
  input wire logic first_ref_buffer_on,
  input wire logic second_ref_buffer_on,
  input wire logic synth_ref_use_sec
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // shadow of the select register; derived outputs lag it by one cycle
  logic [1:0] up_r, up_nxt;
  logic [7:0] sel_r, sel_nxt;
  wire ok = up_r == 2'h3;
  wire rd = pready && !pwrite && paddr == rscd_pkg::ADDR_EDGE_RATE;
  always_comb
  begin
    up_nxt = ok ? up_r : up_r + 2'h1;
    sel_nxt = sel_r;
    if (psel && penable && pready && pwrite && pstrb[0] && paddr == rscd_pkg::ADDR_INSEL)
      sel_nxt = pwdata[7:0];
    if (up_r == 2'h0 || eeprom_reload)
      sel_nxt = eeprom_insel;
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      up_r <= 2'h0;
      sel_r <= 8'h95;
    end
    else
    begin
      up_r <= up_nxt;
      sel_r <= sel_nxt;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    !pready ##1 pready;
  endsequence
  a_apb_one_wait: assert property (s_setup |=> s_wait) else $error("apb wait state wrong");
  a_rise_on_tick: assert property ($rose(aux_divider_zero_clk) |-> $past(prediv_tick))
    else $error("aux clock rose without tick");
  a_edge_one_slow: assert property (rd |=> aux_out_one_slow == ($past(prdata[3:2]) == 2'h2))
    else $error("aux one edge wrong");
  a_edge_zero_slow: assert property (rd |=> aux_out_zero_slow == ($past(prdata[1:0]) == 2'h2))
    else $error("aux zero edge wrong");
  a_sec_kind_field: assert property (second_ref_buffer_kind == sel_r[7:6])
    else $error("second kind wrong");
  a_first_kind_field: assert property (first_ref_buffer_kind == sel_r[5:4])
    else $error("first kind wrong");
  a_sec_buf_on: assert property (ok && $stable(sel_r) |-> second_ref_buffer_on == (sel_r[7:6] != 2'h3))
    else $error("second buffer enable wrong");
  a_first_buf_on: assert property (ok && $stable(sel_r) |-> first_ref_buffer_on == !sel_r[5])
    else $error("first buffer enable wrong");
  a_forced_src: assert property (ok && $stable(sel_r) && sel_r[1] |-> synth_ref_use_sec == sel_r[0])
    else $error("forced source wrong");
  a_pin_src: assert property (ok && $stable(sel_r) && sel_r[1:0] == 2'h1 && $stable(ref_choice_pin)
    && !ref_choice_pin[1] |-> synth_ref_use_sec == ref_choice_pin[0]) else $error("pin source wrong");
endmodule // rscd_checker

bind rscd_top rscd_checker u_chk (.*);

`default_nettype wire

// file: bench/rscd_ref_src.sv
`default_nettype none

module rscd_ref_src (
  // clock
  input wire logic ref_clk,
  // bench controls
  input wire logic prim_run,
  input wire logic sec_run,
  input wire logic [1:0] lvl,
  // device pins
  output var logic prim_ref_in,
  output var logic sec_ref_in,
  output var logic [1:0] ref_choice_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r;
  initial
  begin
    prim_ref_in = 1'b0;
    sec_ref_in = 1'b0;
    ref_choice_pin = 2'h0;
    ph_r = 2'h0;
  end
  // a stopped source holds its level, as a lost clock does
  always @(posedge ref_clk)
  begin
    ph_r <= ph_r + 2'h1;
    if (prim_run)
      prim_ref_in <= !prim_ref_in;
    if (sec_run && ph_r == 2'h3)
      sec_ref_in <= !sec_ref_in;
    ref_choice_pin <= lvl[1] ? 2'h2 : lvl;
  end
endmodule // rscd_ref_src

`default_nettype wire

// file: bench/tb.sv
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} rscd_row_t;
  localparam logic [7:0] A_EDGE = rscd_pkg::ADDR_EDGE_RATE;
  localparam logic [7:0] A_SEL = rscd_pkg::ADDR_INSEL;
  localparam logic [7:0] A_DIV = rscd_pkg::ADDR_AUX_DIV;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, eeprom_reload, prediv_tick;
  logic prim_ref_in, sec_ref_in, prim_run, sec_run, aux_divider_zero_clk, aux_out_one_slow, aux_out_zero_slow;
  logic first_ref_buffer_on, second_ref_buffer_on, synth_ref_use_sec;
  logic [1:0] ref_choice_pin, lvl, first_ref_buffer_kind, second_ref_buffer_kind;
  logic [3:0] pstrb;
  logic [7:0] paddr, eeprom_div, eeprom_edge, eeprom_insel;
  logic [31:0] pwdata, prdata;
  int n_errors = 0;
  int cmp_count = 0;
  rscd_row_t rows [11] = '{'{A_EDGE, 32'h0a, 32'h0a, 1'b0}, '{A_EDGE, 32'h05, 32'h05, 1'b0},
    '{A_EDGE, 32'hff, 32'h0f, 1'b0}, '{A_EDGE, 32'h00, 32'h00, 1'b0}, '{A_SEL, 32'h03, 32'h03, 1'b0},
    '{A_SEL, 32'h56, 32'h56, 1'b0}, '{A_SEL, 32'ha8, 32'ha8, 1'b0}, '{A_SEL, 32'hf5, 32'hf5, 1'b0},
    '{A_SEL, 32'h3e, 32'h3e, 1'b0}, '{A_DIV, 32'h80, 32'h80, 1'b0}, '{8'h10, 32'h12, 32'h00, 1'b1}};
  logic [7:0] codes [4] = '{8'h01, 8'h05, 8'h06, 8'hff};
  int ratio [4] = '{6, 6, 7, 256};

  rscd_top u_dut (.*);
  rscd_ref_src u_src (.*);

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = !ref_clk;
  end
  // tick every other cycle, so a period in cycles is twice the ratio
  always @(posedge ref_clk) prediv_tick <= !prediv_tick;

  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (n >= 20)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic wsec(input logic v);
    int n;
    n = 0;
    while (synth_ref_use_sec !== v && n < 400)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("use_sec", v, synth_ref_use_sec)
    if (n >= 400)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic per(output int p);
    int n;
    int t0;
    n = 0;
    t0 = 0;
    repeat (3)
    begin
      while (aux_divider_zero_clk !== 1'b1 && n < 3000)
      begin
        @(posedge ref_clk);
        n++;
      end
      p = n - t0;
      t0 = n;
      while (aux_divider_zero_clk !== 1'b0 && n < 3000)
      begin
        @(posedge ref_clk);
        n++;
      end
    end
    if (n >= 3000)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  initial
  begin
    logic [31:0] q;
    logic e;
    int p;
    {rst_b, psel, penable, pwrite, eeprom_reload, prediv_tick, paddr, pwdata} = '0;
    {eeprom_div, eeprom_edge, eeprom_insel, pstrb, lvl, prim_run, sec_run} = {24'h000095, 4'hf, 2'h0, 2'h3};
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    // ----------------------------------------------------------------
    // defaults, then the table of accesses, the last one to an unmapped address
    // ----------------------------------------------------------------
    apb(1'b0, A_DIV, 32'h0, q, e);
    `CHK("div", 32'h00, q)
    apb(1'b0, A_EDGE, 32'h0, q, e);
    `CHK("edge", 32'h00, q)
    apb(1'b0, A_SEL, 32'h0, q, e);
    `CHK("sel", 32'h95, q)
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d, q, e);
      apb(1'b0, rows[i].a, 32'h0, q, e);
      `CHK("rd", rows[i].q, q)
      `CHK("err", rows[i].e, e)
    end
    eeprom_div <= 8'h07;
    eeprom_reload <= 1'b1;
    @(posedge ref_clk);
    eeprom_reload <= 1'b0;
    apb(1'b0, A_DIV, 32'h0, q, e);
    `CHK("reload", 32'h07, q)
    // ----------------------------------------------------------------
    // divider ratios, then divider off
    // ----------------------------------------------------------------
    foreach (codes[i])
    begin
      apb(1'b1, A_DIV, {24'h0, codes[i]}, q, e);
      per(p);
      `CHK("period", 2 * ratio[i], p)
    end
    apb(1'b1, A_DIV, 32'h0, q, e);
    repeat (4) @(posedge ref_clk);
    p = 0;
    repeat (600)
    begin
      @(posedge ref_clk);
      if (aux_divider_zero_clk !== 1'b0)
        p++;
    end
    `CHK("div_off", 0, p)
    // ----------------------------------------------------------------
    // source selection by pin, forced, and automatic
    // ----------------------------------------------------------------
    apb(1'b1, A_SEL, 32'h95, q, e);
    wsec(1'b0);
    lvl <= 2'h1;
    wsec(1'b1);
    lvl <= 2'h2;
    wsec(1'b0);
    lvl <= 2'h1;
    wsec(1'b1);
    apb(1'b1, A_SEL, 32'h96, q, e);
    wsec(1'b0);
    apb(1'b1, A_SEL, 32'h94, q, e);
    prim_run <= 1'b0;
    wsec(1'b1);
    prim_run <= 1'b1;
    wsec(1'b0);
    // ----------------------------------------------------------------
    // status view, a write with lane 0 off, then a mid-run reset
    // ----------------------------------------------------------------
    apb(1'b0, rscd_pkg::ADDR_STATUS, 32'h0, q, e);
    `CHK("status", 32'h06, q)
    pstrb <= 4'he;
    apb(1'b1, A_SEL, 32'h00, q, e);
    pstrb <= 4'hf;
    apb(1'b0, A_SEL, 32'h0, q, e);
    `CHK("strb_off", 32'h94, q)
    // new stored defaults differ from the reset pattern, so the load is seen
    eeprom_insel <= 8'h3e;
    eeprom_edge <= 8'h0a;
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK("rst_sec_kind", 2'h2, second_ref_buffer_kind)
    `CHK("rst_first_kind", 2'h1, first_ref_buffer_kind)
    `CHK("rst_use_sec", 1'b0, synth_ref_use_sec)
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    apb(1'b0, A_SEL, 32'h0, q, e);
    `CHK("load_sel", 32'h3e, q)
    apb(1'b0, A_EDGE, 32'h0, q, e);
    `CHK("load_edge", 32'h0a, q)
    end_of_test();
  end
endmodule // tb

`default_nettype wire
